// ===== src/seal_top.sv
/*
  Auto-boot loader: reads a command stream from a serial EEPROM and
  hands each decoded command to the device core.
  Assumes LINK_CLK runs free; the memory updates SDI after our falling
  edge and holds consecutive bytes while chip select stays low.
*/
`timescale 1ns/1ns
`default_nettype none
module seal_top (
  // System clock and reset
  input  wire logic                SYS_CLK,
  input  wire logic                RST_N,
  // Link clock
  input  wire logic                LINK_CLK,
  // Strap
  input  wire logic                MODE,
  // Serial pins
  input  wire logic                CS_N_IN,
  output var  logic                CS_N_OUT,
  output var  logic                CS_N_OE_N,
  input  wire logic                SCLK_IN,
  output var  logic                SCLK_OUT,
  output var  logic                SCLK_OE_N,
  output var  logic                SDO,
  output var  logic                SDO_OE_N,
  input  wire logic                SDI,
  // Command port to the device core
  output var  seal_pkg::seal_cmd_t CMD_OUT,
  output var  logic                CMD_VALID,
  output var  logic                CONV_RUN,
  output var  logic                BOOT_ACTIVE
);
  import seal_pkg::*;

  // System domain
  logic        mode_s1, mode_s2;
  logic [1:0]  strap_cnt;
  logic        boot_req;
  logic        tog_s1, tog_s2, tog_s3;
  logic        done_s1, done_s2;
  logic [1:0]  need;
  logic [7:0]  cur_op;
  logic [15:0] acc;
  logic        stopping;
  logic        byte_evt;
  logic [7:0]  byte_hold;
  logic [23:0] next_data;
  logic        byte_tog;
  logic        link_done;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
    end else begin
      mode_s1 <= MODE;
      mode_s2 <= mode_s1;
    end
  end

  // Strap is caught once, after the synchroniser has filled
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_cnt <= 2'h0;
      boot_req  <= 1'b0;
    end else if (strap_cnt < STRAP_WAIT) begin
      strap_cnt <= strap_cnt + 2'h1;
    end else if (strap_cnt == STRAP_WAIT) begin
      // Counter parks past the sample point, so a late strap is ignored
      strap_cnt <= strap_cnt + 2'h1;
      boot_req  <= (mode_s2 == STRAP_BOOT); // RQ1
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tog_s1  <= 1'b0;
      tog_s2  <= 1'b0;
      tog_s3  <= 1'b0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
    end else begin
      tog_s1  <= byte_tog;
      tog_s2  <= tog_s1;
      tog_s3  <= tog_s2;
      done_s1 <= link_done;
      done_s2 <= done_s1;
    end
  end

  assign byte_evt  = tog_s2 ^ tog_s3;
  assign next_data = {acc, byte_hold};

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BOOT_ACTIVE <= 1'b0;
    end else if (done_s2) begin
      BOOT_ACTIVE <= 1'b0; // RQ11
    end else if (boot_req) begin
      BOOT_ACTIVE <= 1'b1;
    end
  end

  // Stream parser; byte_hold is stable for a whole byte time
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      need      <= 2'h0;
      cur_op    <= 8'h00;
      acc       <= 16'h0000;
      stopping  <= 1'b0;
      CMD_VALID <= 1'b0;
      CMD_OUT   <= '0;
      CONV_RUN  <= 1'b0;
    end else begin
      CMD_VALID <= 1'b0;
      if (byte_evt && !stopping) begin
        if (need == 2'h0) begin
          if (byte_hold[7:6] == WR_TAG && !byte_hold[0]) begin
            cur_op <= byte_hold; // RQ7
            need   <= WR_DATA_BYTES;
          end else begin
            CMD_VALID <= 1'b1; // RQ6 RQ5
            CMD_OUT   <= '{wr: 1'b0, op: byte_hold, data: 24'h00_0000};
            if (byte_hold == CONT_CONV_OP) begin
              CONV_RUN <= 1'b1; // RQ8
            end
          end
        end else begin
          acc  <= next_data[15:0];
          need <= need - 2'h1;
          if (need == 2'h1) begin
            CMD_VALID <= 1'b1; // RQ5 RQ7 RQ10
            CMD_OUT   <= '{wr: 1'b1, op: cur_op, data: next_data};
            if (cur_op == STOP_OPCODE && next_data[STOP_BIT]) begin
              stopping <= 1'b1; // RQ9
            end
          end
        end
      end
    end
  end

  strap_boot_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ1
    strap_cnt == STRAP_WAIT && mode_s2 && !BOOT_ACTIVE && !done_s2
    |=> boot_req ##1 BOOT_ACTIVE) else $error("strap did not start boot");
  write_issue_a: assert property (@(posedge SYS_CLK) // RQ7
    disable iff (!RST_N) byte_evt && !stopping && need == 2'h1
    |=> CMD_VALID && CMD_OUT.wr && CMD_OUT.data[7:0] == $past(byte_hold))
    else $error("write not issued on third data byte");
  single_cmd_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ6
    byte_evt && !stopping && need == 2'h0 && byte_hold[7:6] != WR_TAG
    |=> CMD_VALID && !CMD_OUT.wr && CMD_OUT.op == $past(byte_hold))
    else $error("single byte command lost");
  conv_run_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ8
    CMD_VALID && !CMD_OUT.wr && CMD_OUT.op == CONT_CONV_OP |-> CONV_RUN)
    else $error("continuous conversion not started");
  mask_write_a: assert property (@(posedge SYS_CLK) // RQ10
    disable iff (!RST_N) CMD_VALID && CMD_OUT.op == MASK_WR_OP
    |-> CMD_OUT.wr && need == 2'h0) else $error("mask write malformed");
  stop_seen_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ9
    CMD_VALID && CMD_OUT.wr && CMD_OUT.op == STOP_OPCODE
    && CMD_OUT.data[STOP_BIT] |-> stopping ##1 !CMD_VALID [*8])
    else $error("commands issued after stop");

  // Link domain
  logic          lrst1, lrst_n;
  logic          req_s1, req_s2, stop_s1, stop_s2;
  logic          sdi_s1, sdi_s2;
  seal_lstate_t  lstate;
  logic [1:0]    ph;
  logic [3:0]    bitc;
  logic [15:0]   tx;
  logic [7:0]    rx;

  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lrst1  <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst1  <= 1'b1;
      lrst_n <= lrst1;
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      req_s1  <= 1'b0;
      req_s2  <= 1'b0;
      stop_s1 <= 1'b0;
      stop_s2 <= 1'b0;
      sdi_s1  <= 1'b0;
      sdi_s2  <= 1'b0;
    end else begin
      req_s1  <= boot_req;
      req_s2  <= req_s1;
      stop_s1 <= stopping;
      stop_s2 <= stop_s1;
      sdi_s1  <= SDI;
      sdi_s2  <= sdi_s1;
    end
  end

  // Serial engine; the memory clock is LINK_CLK divided by four
  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      lstate    <= L_IDLE;
      ph        <= 2'h0;
      bitc      <= 4'h0;
      tx        <= 16'h0000;
      rx        <= 8'h00;
      byte_hold <= 8'h00;
      byte_tog  <= 1'b0;
      link_done <= 1'b0;
      CS_N_OUT  <= 1'b1;
      CS_N_OE_N <= 1'b1;
      SCLK_OUT  <= 1'b0;
      SCLK_OE_N <= 1'b1;
      SDO       <= 1'b0;
      SDO_OE_N  <= 1'b1;
    end else begin
      unique case (lstate)
        L_IDLE: begin
          if (req_s2) begin
            lstate    <= L_HDR;
            CS_N_OUT  <= 1'b0; // RQ3
            CS_N_OE_N <= 1'b0; // RQ2
            SCLK_OE_N <= 1'b0; // RQ2
            SDO_OE_N  <= 1'b0;
            tx        <= {READ_OPCODE, START_ADDR}; // RQ4
            ph        <= 2'h0;
            bitc      <= 4'h0;
          end
        end
        L_HDR, L_DATA: begin
          ph <= ph + 2'h1;
          if (ph == PH_FALL) begin
            SCLK_OUT <= 1'b0;
            SDO      <= tx[15]; // RQ3
          end
          if (ph == PH_RISE) begin
            SCLK_OUT <= 1'b1; // RQ3
          end
          if (ph == PH_SAMPLE) begin
            tx   <= {tx[14:0], 1'b0};
            rx   <= {rx[6:0], sdi_s2};
            bitc <= bitc + 4'h1;
            if (lstate == L_HDR && bitc == HDR_LAST_BIT) begin
              lstate <= L_DATA;
              bitc   <= 4'h0;
            end
            if (lstate == L_DATA && bitc[2:0] == BYTE_LAST_BIT) begin
              byte_hold <= {rx[6:0], sdi_s2}; // RQ5
              byte_tog  <= ~byte_tog;
              bitc      <= 4'h0;
              if (stop_s2) begin
                lstate <= L_END;
              end
            end
          end
        end
        L_END: begin
          CS_N_OUT  <= 1'b1; // RQ11
          SCLK_OUT  <= 1'b0; // RQ11
          CS_N_OE_N <= 1'b1;
          SCLK_OE_N <= 1'b1;
          SDO_OE_N  <= 1'b1;
          link_done <= 1'b1;
        end
      endcase
    end
  end

  cs_assert_a: assert property (@(posedge LINK_CLK) // RQ2 RQ3
    disable iff (!lrst_n) lstate == L_IDLE && req_s2
    |=> !CS_N_OUT && !CS_N_OE_N && !SCLK_OE_N)
    else $error("boot did not take the serial pins");
  opcode_out_a: assert property (@(posedge LINK_CLK) // RQ4
    disable iff (!lrst_n) lstate == L_HDR && ph == PH_RISE && bitc < 4'h8
    |-> SDO == READ_OPCODE[3'h7 - bitc[2:0]])
    else $error("wrong read opcode bit");
  sclk_high_a: assert property (@(posedge LINK_CLK) // RQ3
    disable iff (!lrst_n) $rose(SCLK_OUT) && lstate != L_END
    |=> SCLK_OUT ##1 !SCLK_OUT) else $error("serial clock high time wrong");
  boot_end_a: assert property (@(posedge LINK_CLK) // RQ11
    disable iff (!lrst_n) lstate == L_END
    |=> CS_N_OUT && !SCLK_OUT && CS_N_OE_N && link_done ##1 lstate == L_END)
    else $error("link did not release after stop");

endmodule : seal_top
`default_nettype wire

// ===== src/seal_pkg.sv
/*
  Constants and carrier types for the serial EEPROM auto-boot loader.
  Assumes a 100 MHz system clock and a free-running link clock; the
  serial clock sent to the memory is the link clock divided by four.
*/
// Behaviour
// [RQ1] Strap high at reset starts auto-boot
// [RQ2] Drive chip select and clock while booting
// [RQ3] Select low, clock, shift read command out
// [RQ4] Read opcode is fixed 00000011
// [RQ5] Received bytes become device commands and writes
// [RQ6] Every host command accepted from the stream
// [RQ7] Write is command byte plus three data
// [RQ8] Single byte F8 starts continuous conversion
// [RQ9] Stop bit write to control ends boot
// [RQ10] Mask register write passes to the device
// [RQ11] After stop raise select, stop clock, leave
package seal_pkg;

  localparam logic [7:0]  READ_OPCODE    = 8'h03;
  localparam logic [7:0]  START_ADDR     = 8'h00;
  localparam logic [1:0]  WR_TAG         = 2'h1;
  localparam logic [1:0]  WR_DATA_BYTES  = 2'h3;
  localparam logic [7:0]  STOP_OPCODE    = 8'h78;
  localparam int          STOP_BIT       = 8;
  localparam logic [7:0]  CONT_CONV_OP   = 8'hF8;
  localparam logic [7:0]  MASK_WR_OP     = 8'h74;
  localparam logic        STRAP_BOOT     = 1'h1;
  localparam logic [1:0]  STRAP_WAIT     = 2'h2;
  localparam logic [1:0]  PH_FALL        = 2'h0;
  localparam logic [1:0]  PH_RISE        = 2'h2;
  localparam logic [1:0]  PH_SAMPLE      = 2'h3;
  localparam logic [3:0]  HDR_LAST_BIT   = 4'hF;
  localparam logic [2:0]  BYTE_LAST_BIT  = 3'h7;

  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_HDR  = 2'b01,
    L_DATA = 2'b10,
    L_END  = 2'b11
  } seal_lstate_t;

  typedef struct packed {
    logic        wr;
    logic [7:0]  op;
    logic [23:0] data;
  } seal_cmd_t;

endpackage : seal_pkg

// ===== verification/seal_eeprom.sv
/*
  Serial memory model: takes the 16-bit read header, then streams the
  image bytes MSB first after each falling serial clock edge.
  Assumes mode-0 clocking and an active-low select.
*/
`timescale 1ns/1ns
`default_nettype none
module seal_eeprom (
  // Serial pins
  input  wire logic         cs_n,
  input  wire logic         sclk,
  input  wire logic         mosi,
  output var  logic         miso,
  // Stored image, answer pace, captured header
  input  wire logic [255:0] image,
  input  wire logic         slow,
  output var  logic [15:0]  hdr
);
  logic [4:0] hcnt;
  logic [7:0] bitp;

  initial begin
    miso = 1'b0;
    hdr  = 16'h0000;
  end
  always @(negedge cs_n) begin
    hcnt = 5'h00;
    bitp = 8'h00;
  end
  // Released line shows no stale value
  always @(posedge cs_n) miso <= ~miso;
  always @(posedge sclk) begin
    if (!cs_n && hcnt < 5'h10) begin
      hdr  = {hdr[14:0], mosi};
      hcnt = hcnt + 5'h01;
    end
  end
  // Consecutive bytes while selected, prompt or late
  always @(negedge sclk) begin
    if (!cs_n && hcnt == 5'h10) begin
      miso <= #(slow ? 40 : 2) image[8'hFF - bitp];
      bitp = bitp + 8'h01;
    end
  end
endmodule : seal_eeprom
`default_nettype wire

// ===== verification/seal_top_tb.sv
/*
  Bench for the auto-boot loader: one power-up with the strap low,
  then two boots against a prompt and a slow memory.
  Assumes the design's own assertions are active.
*/
`timescale 1ns/1ns
`default_nettype none
module seal_top_tb;
  import seal_pkg::*;
  logic         SYS_CLK  = 1'b0;
  logic         LINK_CLK = 1'b0;
  logic         RST_N    = 1'b0;
  logic         MODE     = 1'b0;
  logic         slow     = 1'b0;
  logic [255:0] image    = '0;
  logic         CS_N_OUT, CS_N_OE_N, SCLK_OUT, SCLK_OE_N, SDO, SDO_OE_N, SDI;
  logic         CMD_VALID, CONV_RUN, BOOT_ACTIVE, conv_exp;
  logic [15:0]  hdr;
  seal_cmd_t    CMD_OUT, exp_cmd;
  seal_cmd_t    expect_q[$];
  int           mismatches = 0;
  int           checks     = 0;
  // Pull-up on select, pull-down on serial clock
  wire logic    cs_pin   = CS_N_OE_N ? 1'b1 : CS_N_OUT;
  wire logic    sclk_pin = SCLK_OE_N ? 1'b0 : SCLK_OUT;

  always #5 SYS_CLK = ~SYS_CLK;
  // Link clock starts off phase from the system clock
  initial begin
    #7;
    forever #24 LINK_CLK = ~LINK_CLK;
  end

  seal_top i_seal_top (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .LINK_CLK(LINK_CLK), .MODE(MODE), .CS_N_IN(cs_pin),
    .CS_N_OUT(CS_N_OUT), .CS_N_OE_N(CS_N_OE_N), .SCLK_IN(sclk_pin),
    .SCLK_OUT(SCLK_OUT), .SCLK_OE_N(SCLK_OE_N), .SDO(SDO),
    .SDO_OE_N(SDO_OE_N), .SDI(SDI), .CMD_OUT(CMD_OUT),
    .CMD_VALID(CMD_VALID), .CONV_RUN(CONV_RUN), .BOOT_ACTIVE(BOOT_ACTIVE));
  seal_eeprom i_seal_eeprom (.cs_n(cs_pin), .sclk(sclk_pin), .mosi(SDO),
    .miso(SDI), .image(image), .slow(slow), .hdr(hdr));

  task automatic check(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : check

  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic do_reset();
    RST_N = 1'b0;
    repeat (10) @(posedge SYS_CLK);
    #1 RST_N = 1'b1;
  endtask : do_reset

  task automatic boot(input logic s);
    logic [7:0]  wop, rop;
    logic [23:0] wdat;
    wop  = {2'b01, 5'($urandom), 1'b0};
    if (wop == STOP_OPCODE) wop = 8'h40;
    rop  = 8'($urandom);
    if (rop[7:6] == 2'b01) rop[0] = 1'b1;
    if (rop == CONT_CONV_OP) rop = 8'hA0;
    wdat = 24'($urandom);
    image = {8'h64, 24'h00_0060, wop, wdat, rop, 8'h74, 24'h00_0004,
             8'hF8, 8'h78, 24'h00_0100, {14{8'h64}}};
    expect_q.push_back({1'b1, 8'h64, 24'h00_0060});
    expect_q.push_back({1'b1, wop, wdat});
    expect_q.push_back({1'b0, rop, 24'h00_0000});
    expect_q.push_back({1'b1, 8'h74, 24'h00_0004});
    expect_q.push_back({1'b0, 8'hF8, 24'h00_0000});
    expect_q.push_back({1'b1, 8'h78, 24'h00_0100});
    slow = s;
    MODE = 1'b1;
    do_reset();
    for (int i = 0; i < 400 && cs_pin !== 1'b0; i++) @(posedge SYS_CLK);
    #2;
    check(BOOT_ACTIVE === 1'b1, "boot not active");
    check({CS_N_OE_N, SCLK_OE_N, SDO_OE_N} === 3'b000, "pins idle");
    for (int i = 0; i < 8000 && BOOT_ACTIVE !== 1'b0; i++) @(posedge SYS_CLK);
    check(BOOT_ACTIVE === 1'b0, "boot did not end");
    repeat (20) @(posedge SYS_CLK);
    #1;
    check(hdr === {READ_OPCODE, START_ADDR}, "read header");
    check(expect_q.size() == 0, "commands missing");
    check(CONV_RUN === 1'b1, "conversion not started");
    check({cs_pin, CS_N_OE_N, SCLK_OUT} === 3'b110, "link not ended");
  endtask : boot

  // Each decoded command against the oldest expectation
  always @(negedge SYS_CLK) begin
    if (RST_N !== 1'b1) conv_exp = 1'b0;
    if (CMD_VALID === 1'b1) begin
      if (expect_q.size() == 0) check(1'b0, "extra command");
      else begin
        exp_cmd = expect_q.pop_front();
        check(CMD_OUT === exp_cmd, "command mismatch");
        if (!exp_cmd.wr && exp_cmd.op == CONT_CONV_OP) conv_exp = 1'b1;
        check(CONV_RUN === conv_exp, "conversion flag");
      end
    end
  end

  initial begin
    void'($urandom(11988));
    do_reset();
    repeat (150) @(posedge SYS_CLK);
    // Strap raised long after reset must not start a boot
    #1 MODE = 1'b1;
    repeat (150) @(posedge SYS_CLK);
    #1;
    check({BOOT_ACTIVE, cs_pin, CS_N_OE_N} === 3'b011, "late strap");
    boot(1'b0);
    boot(1'b1);
    tally_and_finish();
  end

  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule : seal_top_tb
`default_nettype wire
